// File: hw/ttf_regs.vh
`ifndef TTF_REGS_VH
`define TTF_REGS_VH

// debug_control_reg field positions
`define TTF_CTRL_EN_BIT      7
`define TTF_CTRL_ARM_BIT     6
`define TTF_CTRL_TAG_BIT     5
`define TTF_CTRL_BREAKPOINT_ENABLE_BIT   4

// trigger_config_reg field positions
`define TTF_TRIG_SEL_BIT     7
`define TTF_TRIG_BEGIN_BIT   6
`define TTF_TRIG_MODE_HI     3
`define TTF_TRIG_MODE_LO     0

// debug_status_reg field positions
`define TTF_STAT_AF_BIT      7
`define TTF_STAT_BF_BIT      6
`define TTF_STAT_CF_BIT      5
`define TTF_STAT_ARMED_FLAG_BIT    0

// default begin trace loaded at reset
`define TTF_CTRL_RST         8'hC0
`define TTF_TRIG_RST         8'h40
`define TTF_CMPA_RST         17'h0_FFFE

// trigger mode codes
`define TTF_MODE_A_ONLY      4'h0
`define TTF_MODE_A_OR_B      4'h1
`define TTF_MODE_A_THEN_B    4'h2
`define TTF_MODE_EVT_B       4'h3
`define TTF_MODE_A_THEN_EVT  4'h4
`define TTF_MODE_A_AND_B     4'h5
`define TTF_MODE_A_NOT_B     4'h6
`define TTF_MODE_INSIDE      4'h7
`define TTF_MODE_OUTSIDE     4'h8

// trace storage
`define TTF_FIFO_DEPTH       8
`define TTF_BRANCH_BACK      17'h0_0002

`endif

// File: hw/ttf_trace_mem.v
`timescale 1ns/1ps
`default_nettype none

// small trace store, registered read data
module ttf_trace_mem #(
  parameter W     = 18,
  parameter DEPTH = 8,
  parameter PTRW  = 3
) (
  // clock and reset
  input  wire            mclk,
  input  wire            reset,
  // write side
  input  wire            wr_en,
  input  wire [PTRW-1:0] wr_addr,
  input  wire [W-1:0]    wr_data,
  // read side
  input  wire [PTRW-1:0] rd_addr,
  output reg  [W-1:0]    rd_data
);

  reg [W-1:0] mem [0:DEPTH-1];

  // contents survive reset so a trace can be read afterwards
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read register
  always @(posedge mclk) begin
    if (reset) begin
      rd_data <= {W{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// File: hw/ttf_trace_trigger.v
// Operation
// - a-and-not-b: address a, data not b
// - a-and-not-b end tag breaks use a only
// - inside and outside range flag setting
// - four bits pick run type; no breakpoint_enable, no break
// - end trace: fill until trigger, then break
// - begin trace: start at trigger, break when full
// - eight words of change-of-flow addresses
// - event modes store data byte, upper zero
// - indirect change of flow stores current address
// - taken branch stores previous address minus two
// - begin run stores after trigger until eight
// - end run stores until trigger, then disarms
// - readable when enabled, shifts only unarmed, oldest first
// - low byte read shifts, count unchanged
// - armed read returns oldest, no shift
// - unarmed low read stores current opcode address
// - qualified trigger suppressed by pending interrupt
// - unqualified end trigger skips interrupt change record
// - unqualified begin trigger records interrupt change
// - reset in end trace clears only arm and breakpoint enable bits
// - other resets load default begin trace
// - arming clears a, b, c flags
// - event modes behave as begin type, except at reset, where only the begin bit selects end trace
`timescale 1ns/1ps
`default_nettype none
`include "ttf_regs.vh"

module ttf_trace_trigger #(
  parameter AW    = 17,
  parameter DEPTH = `TTF_FIFO_DEPTH,
  parameter PTRW  = 3
) (
  // clock and reset
  input  wire            mclk,
  input  wire            reset,
  input  wire            power_on_reset,
  // core bus and change of flow
  input  wire [AW-1:0]   core_addr,
  input  wire            core_paged,
  input  wire [7:0]      core_data,
  input  wire            core_bus_valid,
  input  wire [1:0]      core_cof,
  input  wire            core_op_top,
  input  wire [AW-1:0]   core_op_addr,
  input  wire            core_irq_pending,
  // software writes
  input  wire            ctrl_wr,
  input  wire [7:0]      ctrl_wdata,
  input  wire            trig_wr,
  input  wire [7:0]      trig_wdata,
  input  wire            cmp_a_wr,
  input  wire [AW-1:0]   cmp_a_wdata,
  input  wire            cmp_b_wr,
  input  wire [AW-1:0]   cmp_b_wdata,
  input  wire            cmp_c_wr,
  input  wire [AW-1:0]   cmp_c_wdata,
  // status
  output wire [7:0]      debug_control_reg,
  output wire [7:0]      trigger_config_reg,
  output wire [7:0]      debug_status_reg,
  output wire [PTRW:0]   valid_word_count,
  // trace readout request
  input  wire            rd_req_valid,
  output wire            rd_req_ready,
  input  wire            rd_req_low,
  // trace readout answer
  output wire            rd_rsp_valid,
  input  wire            rd_rsp_ready,
  output wire [7:0]      fifo_extended_byte,
  output wire [7:0]      fifo_high_byte,
  output wire [7:0]      fifo_low_byte,
  // break requests to the core
  output reg             brk_force,
  output reg             brk_tag
);

  localparam EW = AW + 1;
  localparam [PTRW:0] FULL_CNT = DEPTH;
  localparam [PTRW:0] LAST_CNT = DEPTH - 1;

  wire [7:0] ctrl_rst = `TTF_CTRL_RST;
  wire [7:0] trig_rst = `TTF_TRIG_RST;

  // event-only mode decode
  function is_event;
    input [3:0] mode;
    begin
      is_event = (mode == `TTF_MODE_EVT_B) || (mode == `TTF_MODE_A_THEN_EVT);
    end
  endfunction

  // control and status state
  reg            en_q, arm_q, tag_q, brk_en_q, armed_q;
  reg            opcode_qualify_select_q, begin_q;
  reg  [3:0]     mode_q;
  reg  [AW-1:0]  cmp_a_q, cmp_b_q, cmp_c_q;
  reg            match_a_flag, match_b_flag, match_c_flag;
  reg            a_seen_q, triggered_q;
  reg  [PTRW-1:0] wptr_q, rptr_q;
  reg  [PTRW:0]  count_q;
  reg  [AW-1:0]  prev_addr_q;
  reg            moved_q;
  // answer buffer
  reg  [23:0]    buf0_q, buf1_q;
  reg  [1:0]     bcnt_q;
  wire [EW-1:0]  mem_rdata;

  // run type decode
  wire evt_mode  = is_event(mode_q);
  wire begin_eff = begin_q | evt_mode;
  wire run_armed = arm_q & en_q;

  // comparator source, qualified by opcode tracking when selected
  wire [AW-1:0] cmp_addr = opcode_qualify_select_q ? core_op_addr : core_addr;
  wire cmp_stb = opcode_qualify_select_q ? (core_op_top & ~core_irq_pending) : core_bus_valid;
  wire a_m   = cmp_stb & (cmp_addr == cmp_a_q);
  wire b_m   = cmp_stb & (cmp_addr == cmp_b_q);
  wire b_evt = core_bus_valid & (core_addr == cmp_b_q);
  wire b_dat = core_bus_valid & (core_data == cmp_b_q[7:0]);
  wire c_m   = core_bus_valid & (core_addr == cmp_c_q);
  wire in_rng = cmp_stb & (cmp_addr >= cmp_a_q) & (cmp_addr <= cmp_b_q);

  // per-mode flag and trigger decode
  reg set_a, set_b, trig;
  always @* begin
    set_a = 1'b0;
    set_b = 1'b0;
    case (mode_q)
      `TTF_MODE_A_ONLY: begin
        set_a = a_m;
      end
      `TTF_MODE_A_OR_B: begin
        set_a = a_m;
        set_b = b_m;
      end
      `TTF_MODE_A_THEN_B: begin
        set_a = a_m;
        set_b = b_m & a_seen_q;
      end
      `TTF_MODE_EVT_B: begin
        set_b = b_evt;
      end
      `TTF_MODE_A_THEN_EVT: begin
        set_a = a_m;
        set_b = b_evt & a_seen_q;
      end
      `TTF_MODE_A_AND_B: begin
        set_a = a_m & b_dat;
        set_b = a_m & b_dat;
      end
      `TTF_MODE_A_NOT_B: begin
        set_a = a_m & ~b_dat;
        set_b = a_m & ~b_dat;
      end
      `TTF_MODE_INSIDE: begin
        set_a = in_rng;
        set_b = in_rng;
      end
      `TTF_MODE_OUTSIDE: begin
        set_a = cmp_stb & (cmp_addr < cmp_a_q);
        set_b = cmp_stb & (cmp_addr > cmp_b_q);
      end
      default: begin
        set_a = 1'b0;
        set_b = 1'b0;
      end
    endcase
    case (mode_q)
      `TTF_MODE_A_ONLY:     trig = set_a;
      `TTF_MODE_A_OR_B:     trig = set_a | set_b;
      `TTF_MODE_OUTSIDE:    trig = set_a | set_b;
      `TTF_MODE_A_THEN_B:   trig = set_b;
      `TTF_MODE_EVT_B:      trig = set_b;
      `TTF_MODE_A_THEN_EVT: trig = set_b;
      default:              trig = set_a & set_b;
    endcase
  end

  // storage decisions
  wire trig_go = run_armed & trig;
  wire started = triggered_q | trig_go;
  wire [AW-1:0] cof_addr = core_cof[1] ? core_addr
                                       : prev_addr_q - `TTF_BRANCH_BACK;
  wire end_irq_skip = ~begin_eff & trig_go & core_irq_pending;
  wire store_cof = run_armed & ~evt_mode & (|core_cof) &
                   (begin_eff ? started : ~end_irq_skip);
  wire store_evt = run_armed & evt_mode & trig_go;
  wire store_run = store_cof | store_evt;
  wire [EW-1:0] run_wdata = evt_mode ? {{(EW-8){1'b0}}, core_data}
                                     : {core_paged, cof_addr};
  wire fill_done = begin_eff & store_run & (count_q == LAST_CNT);
  wire end_done  = ~begin_eff & trig_go;
  wire run_end   = fill_done | end_done;

  // readout handshake and profile capture
  wire rd_acc   = rd_req_valid & rd_req_ready;
  wire rd_shift = rd_acc & rd_req_low & en_q & ~arm_q;
  wire overwrite = store_run & (count_q == FULL_CNT);
  wire mem_we = store_run | rd_shift;
  wire [PTRW-1:0] mem_waddr = rd_shift ? rptr_q : wptr_q;
  wire [EW-1:0] mem_wdata = rd_shift ? {core_paged, core_op_addr} : run_wdata;

  // next control values
  wire en_d  = ctrl_wr ? ctrl_wdata[`TTF_CTRL_EN_BIT] : en_q;
  wire arm_d = ctrl_wr ? ctrl_wdata[`TTF_CTRL_ARM_BIT] : (run_end ? 1'b0 : arm_q);
  wire arm_start = ctrl_wr & ctrl_wdata[`TTF_CTRL_ARM_BIT] & ctrl_wdata[`TTF_CTRL_EN_BIT];

  // tag source; a-and-not-b end traces watch comparator a alone
  wire tag_hit = (~begin_eff & ((mode_q == `TTF_MODE_A_NOT_B) ? a_m : trig)) | c_m;

  ttf_trace_mem #(
    .W     (EW),
    .DEPTH (DEPTH),
    .PTRW  (PTRW)
  ) u_mem (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (rptr_q),
    .rd_data (mem_rdata)
  );

  // control, flags, pointers and break requests
  always @(posedge mclk) begin
    if (reset) begin
      if (en_q & ~begin_q & ~power_on_reset) begin
        arm_q    <= 1'b0;
        armed_q  <= 1'b0;
        brk_en_q <= 1'b0;
      end else begin
        en_q         <= ctrl_rst[`TTF_CTRL_EN_BIT];
        arm_q        <= ctrl_rst[`TTF_CTRL_ARM_BIT];
        armed_q      <= ctrl_rst[`TTF_CTRL_ARM_BIT];
        tag_q        <= ctrl_rst[`TTF_CTRL_TAG_BIT];
        brk_en_q     <= ctrl_rst[`TTF_CTRL_BREAKPOINT_ENABLE_BIT];
        opcode_qualify_select_q     <= trig_rst[`TTF_TRIG_SEL_BIT];
        begin_q      <= trig_rst[`TTF_TRIG_BEGIN_BIT];
        mode_q       <= trig_rst[`TTF_TRIG_MODE_HI:`TTF_TRIG_MODE_LO];
        cmp_a_q      <= `TTF_CMPA_RST;
        cmp_b_q      <= {AW{1'b0}};
        cmp_c_q      <= {AW{1'b0}};
        match_a_flag <= 1'b0;
        match_b_flag <= 1'b0;
        match_c_flag <= 1'b0;
        a_seen_q     <= 1'b0;
        triggered_q  <= 1'b0;
        wptr_q       <= {PTRW{1'b0}};
        rptr_q       <= {PTRW{1'b0}};
        count_q      <= {(PTRW+1){1'b0}};
      end
      prev_addr_q <= {AW{1'b0}};
      moved_q     <= 1'b0;
      brk_force   <= 1'b0;
      brk_tag     <= 1'b0;
    end else begin
      prev_addr_q <= core_addr;
      en_q        <= en_d;
      arm_q       <= arm_d;
      armed_q     <= arm_d & en_d;
      if (ctrl_wr) begin
        tag_q    <= ctrl_wdata[`TTF_CTRL_TAG_BIT];
        brk_en_q <= ctrl_wdata[`TTF_CTRL_BREAKPOINT_ENABLE_BIT];
      end
      if (trig_wr) begin
        opcode_qualify_select_q <= trig_wdata[`TTF_TRIG_SEL_BIT];
        begin_q  <= trig_wdata[`TTF_TRIG_BEGIN_BIT];
        mode_q   <= trig_wdata[`TTF_TRIG_MODE_HI:`TTF_TRIG_MODE_LO];
      end
      if (cmp_a_wr) cmp_a_q <= cmp_a_wdata;
      if (cmp_b_wr) cmp_b_q <= cmp_b_wdata;
      if (cmp_c_wr) cmp_c_q <= cmp_c_wdata;
      // arming restarts the run
      if (arm_start) begin
        match_a_flag <= 1'b0;
        match_b_flag <= 1'b0;
        match_c_flag <= 1'b0;
        a_seen_q     <= 1'b0;
        triggered_q  <= 1'b0;
        wptr_q       <= {PTRW{1'b0}};
        rptr_q       <= {PTRW{1'b0}};
        count_q      <= {(PTRW+1){1'b0}};
      end else begin
        if (run_armed & set_a) match_a_flag <= 1'b1;
        if (run_armed & set_b) match_b_flag <= 1'b1;
        if (run_armed & c_m)   match_c_flag <= 1'b1;
        if (run_armed & a_m)   a_seen_q     <= 1'b1;
        if (trig_go)           triggered_q  <= 1'b1;
        if (store_run) begin
          wptr_q <= wptr_q + 1'b1;
          if (count_q != FULL_CNT) count_q <= count_q + 1'b1;
        end
        if (overwrite | rd_shift) rptr_q <= rptr_q + 1'b1;
      end
      moved_q   <= overwrite | rd_shift;
      brk_force <= en_q & brk_en_q & ~tag_q & (run_end | (c_m & ~run_armed));
      brk_tag   <= en_q & brk_en_q & tag_q & tag_hit;
    end
  end

  // answer word: zero when disabled or empty, upper bytes zero in event modes
  wire ent_ok = en_q & (count_q != {(PTRW+1){1'b0}});
  wire [7:0] ans_x = (ent_ok & ~evt_mode) ? {mem_rdata[EW-1], 6'h00, mem_rdata[AW-1]} : 8'h00;
  wire [7:0] ans_h = (ent_ok & ~evt_mode) ? mem_rdata[15:8] : 8'h00;
  wire [7:0] ans_l = ent_ok ? mem_rdata[7:0] : 8'h00;
  wire [23:0] ans_word = {ans_x, ans_h, ans_l};

  // two-entry answer buffer; stalls requests while full or while read data settles
  wire rsp_pop = rd_rsp_valid & rd_rsp_ready;
  assign rd_req_ready = (bcnt_q != 2'd2) & ~moved_q;
  assign rd_rsp_valid = (bcnt_q != 2'd0);
  always @(posedge mclk) begin
    if (reset) begin
      buf0_q <= 24'h00_0000;
      buf1_q <= 24'h00_0000;
      bcnt_q <= 2'd0;
    end else begin
      case ({rd_acc, rsp_pop})
        2'b10: begin
          if (bcnt_q == 2'd0) buf0_q <= ans_word;
          else buf1_q <= ans_word;
          bcnt_q <= bcnt_q + 2'd1;
        end
        2'b01: begin
          buf0_q <= buf1_q;
          bcnt_q <= bcnt_q - 2'd1;
        end
        2'b11: begin
          if (bcnt_q == 2'd1) begin
            buf0_q <= ans_word;
          end else begin
            buf0_q <= buf1_q;
            buf1_q <= ans_word;
          end
        end
        default: begin
          bcnt_q <= bcnt_q;
        end
      endcase
    end
  end

  // status and readout outputs
  assign fifo_extended_byte = buf0_q[23:16];
  assign fifo_high_byte     = buf0_q[15:8];
  assign fifo_low_byte      = buf0_q[7:0];
  assign valid_word_count   = count_q;
  assign debug_control_reg  = {en_q, arm_q, tag_q, brk_en_q, 4'h0};
  assign trigger_config_reg = {opcode_qualify_select_q, begin_q, 2'b00, mode_q};
  assign debug_status_reg   = {match_a_flag, match_b_flag, match_c_flag, 4'h0, armed_q};

endmodule

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, reset = 1, por = 1, cv = 0, rqv = 0, rql = 0, rsr = 0, brk_force, brk_tag;
  logic [16:0] ca = 0, addr, opa, exp_q [8];
  logic [7:0] cd = 0, data, ctrl, trig, stat, x, h, l;
  logic [1:0] cc = 0, cof;
  logic [3:0] cnt;
  logic bv, rq_rdy, rs_v;
  logic [3:0] wr = 0;
  logic [16:0] wv = 0;
  int fail_count = 0, checks = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  ttf_core_model u_core (.mclk(mclk), .cmd_valid(cv), .cmd_addr(ca), .cmd_data(cd), .cmd_cof(cc),
    .core_addr(addr), .core_data(data), .core_bus_valid(bv), .core_cof(cof), .core_op_addr(opa));
  ttf_trace_trigger DUT (.mclk(mclk), .reset(reset), .power_on_reset(por), .core_addr(addr),
    .core_paged(1'b0), .core_data(data), .core_bus_valid(bv), .core_cof(cof), .core_op_top(1'b0),
    .core_op_addr(opa), .core_irq_pending(1'b0), .ctrl_wr(wr[0]), .ctrl_wdata(wv[7:0]),
    .trig_wr(wr[1]), .trig_wdata(wv[7:0]), .cmp_a_wr(wr[2]), .cmp_a_wdata(wv), .cmp_b_wr(wr[3]),
    .cmp_b_wdata(wv), .cmp_c_wr(1'b0), .cmp_c_wdata(17'h0_0000), .debug_control_reg(ctrl),
    .trigger_config_reg(trig), .debug_status_reg(stat), .valid_word_count(cnt),
    .rd_req_valid(rqv), .rd_req_ready(rq_rdy), .rd_req_low(rql), .rd_rsp_valid(rs_v),
    .rd_rsp_ready(rsr), .fifo_extended_byte(x), .fifo_high_byte(h), .fifo_low_byte(l),
    .brk_force(brk_force), .brk_tag(brk_tag));
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // register write: 0 control, 1 trigger, 2 comparator a, 3 comparator b
  task automatic wrr(input int sel, input logic [16:0] v);
    wr <= 4'h1 << sel;
    wv <= v;
    @(posedge mclk);
    wr <= 4'h0;
    @(posedge mclk);
  endtask
  // one core bus cycle; last releases the command afterwards
  task automatic bus(input logic [16:0] a, input logic [7:0] d, input logic [1:0] c, input bit last);
    cv <= 1;
    ca <= a;
    cd <= d;
    cc <= c;
    @(posedge mclk);
    if (last) begin
      cv <= 0;
      @(posedge mclk);
    end
  endtask
  // readout request, then answer taken and popped
  task automatic rd(input logic low);
    rqv <= 1;
    rql <= low;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (rq_rdy === 1'b1) break;
    end
    rqv <= 0;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (rs_v === 1'b1) break;
    end
    rsr <= 1;
    @(posedge mclk);
    rsr <= 0;
  endtask
  task automatic wait_brk;
    for (int n = 0; n < 20 && brk_force !== 1'b1; n++) @(posedge mclk);
    chk(brk_force, 1);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    chk({ctrl, trig, stat[0]}, {8'hc0, 8'h40, 1'b1});
    wrr(0, 17'h0_00d0); // default run has no breakpoint; enable force breaks and rearm
    bus(17'h0_0100, 8'h00, 2'b10, 1);
    bus(17'h0_fffe, 8'h00, 2'b00, 1);
    chk(cnt, 0);
    for (int i = 0; i < 8; i++) begin
      if (i == 3) begin
        bus(17'h0_2000, 8'h00, 2'b00, 0);
        bus(17'h1_2100, 8'h00, 2'b01, 1);
        exp_q[i] = 17'h0_1ffe;
      end else begin
        exp_q[i] = 17'h0_1000 + 17'(i * 16);
        bus(exp_q[i], 8'h00, 2'b10, 1);
      end
    end
    wait_brk();
    chk({cnt, stat[0]}, {4'h8, 1'b0});
    rd(0);
    chk({x, h, l}, {7'h00, exp_q[0]});
    for (int i = 0; i < 8; i++) begin
      rd(1);
      chk({x, h, l}, {7'h00, exp_q[i]});
    end
    chk(cnt, 8);
    wrr(1, 17'h0_0000); // end trace on a only, without qualification
    wrr(2, 17'h0_3000);
    wrr(0, 17'h0_00d0);
    bus(17'h0_4000, 8'h00, 2'b10, 1);
    bus(17'h0_4100, 8'h00, 2'b10, 1);
    bus(17'h0_3000, 8'h00, 2'b10, 1);
    wait_brk();
    bus(17'h0_4200, 8'h00, 2'b10, 1);
    @(posedge mclk);
    chk({cnt, stat[0], ctrl}, {4'h3, 1'b0, 8'h90});
    por <= 0;
    reset <= 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    chk({ctrl, trig, cnt}, {8'h80, 8'h00, 4'h3});
    rd(1);
    chk({x, h, l}, 24'h00_4000);
    rd(1);
    rd(1);
    chk({x, h, l}, 24'h00_3000);
    wrr(1, 17'h0_0006);
    wrr(2, 17'h0_0500);
    wrr(3, 17'h0_005a);
    wrr(0, 17'h0_00c0);
    bus(17'h0_0500, 8'h5a, 2'b00, 1);
    @(posedge mclk);
    chk(stat[7:6], 2'b00);
    bus(17'h0_0500, 8'h33, 2'b00, 1);
    @(posedge mclk);
    chk(stat[7:6], 2'b11);
    wrr(1, 17'h0_0007);
    wrr(2, 17'h0_0100);
    wrr(3, 17'h0_0200);
    wrr(0, 17'h0_00c0);
    chk(stat[7:5], 3'b000);
    bus(17'h0_0180, 8'h00, 2'b00, 1);
    @(posedge mclk);
    chk(stat[7:6], 2'b11);
    wrr(0, 17'h0_0000);
    rd(1);
    chk({x, h, l}, 24'h00_0000);
    por <= 1;
    reset <= 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    chk({ctrl, trig, cnt}, {8'hc0, 8'h40, 4'h0});
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: tb/ttf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core side: one bus cycle per command, changing idle pattern otherwise
module ttf_core_model (
  // clock
  input  wire logic        mclk,
  // command from the bench
  input  wire logic        cmd_valid,
  input  wire logic [16:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic [1:0]  cmd_cof,
  // core bus toward the block
  output logic [16:0] core_addr,
  output logic [7:0]  core_data,
  output logic        core_bus_valid,
  output logic [1:0]  core_cof,
  output logic [16:0] core_op_addr
);
  logic [15:0] idle_q = 16'h0000;
  // idle cycles never repeat the last address
  always @(posedge mclk) begin
    idle_q         <= idle_q + 16'h0101;
    core_op_addr   <= {1'b1, ~idle_q};
    core_bus_valid <= cmd_valid;
    core_addr      <= cmd_valid ? cmd_addr : {1'b1, idle_q};
    core_data      <= cmd_valid ? cmd_data : ~idle_q[7:0];
    core_cof       <= cmd_valid ? cmd_cof : 2'b00;
  end
endmodule
`default_nettype wire

// File: tb/ttf_trace_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the trace and trigger block
module ttf_trace_checker #(
  parameter PTRW = 3
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          power_on_reset,
  // control write and registers
  input  wire logic          ctrl_wr,
  input  wire logic [7:0]    ctrl_wdata,
  input  wire logic [7:0]    debug_control_reg,
  input  wire logic [7:0]    trigger_config_reg,
  input  wire logic [7:0]    debug_status_reg,
  input  wire logic [PTRW:0] valid_word_count,
  // readout
  input  wire logic          rd_req_valid,
  input  wire logic          rd_req_ready,
  input  wire logic          rd_req_low,
  input  wire logic          rd_rsp_valid,
  input  wire logic          rd_rsp_ready,
  input  wire logic [7:0]    fifo_low_byte,
  // break
  input  wire logic          brk_force
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_count_max: assert property (valid_word_count <= 8)
    else $error("word count above depth");
  a_lowrd_count: assert property (rd_req_valid && rd_req_ready && rd_req_low
    && !debug_status_reg[0] && !ctrl_wr |=> $stable(valid_word_count))
    else $error("count moved on low read");
  a_rsp_next: assert property (rd_req_valid && rd_req_ready |=> rd_rsp_valid)
    else $error("no answer after read");
  a_rsp_hold: assert property (rd_rsp_valid && !rd_rsp_ready |=>
    rd_rsp_valid && $stable(fifo_low_byte))
    else $error("answer dropped before pop");
  a_arm_clears: assert property (ctrl_wr && ctrl_wdata[7:6] == 2'b11 |=>
    debug_status_reg[7:5] == 3'b000 && debug_status_reg[0])
    else $error("arming left flags set");
  a_reset_default: assert property ($fell(reset) && $past(power_on_reset) |->
    debug_control_reg == 8'hc0 && trigger_config_reg == 8'h40)
    else $error("default trace not loaded");
  a_brk_pulse: assert property (brk_force |=> !brk_force)
    else $error("break longer than one cycle");
  a_ctrl_write: assert property (ctrl_wr |=> debug_control_reg == $past(ctrl_wdata))
    else $error("control write lost");
endmodule
bind ttf_trace_trigger ttf_trace_checker #(.PTRW(PTRW)) u_chk (.mclk(mclk), .reset(reset),
  .power_on_reset(power_on_reset), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
  .debug_control_reg(debug_control_reg), .trigger_config_reg(trigger_config_reg),
  .debug_status_reg(debug_status_reg), .valid_word_count(valid_word_count),
  .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_req_low(rd_req_low),
  .rd_rsp_valid(rd_rsp_valid), .rd_rsp_ready(rd_rsp_ready), .fifo_low_byte(fifo_low_byte),
  .brk_force(brk_force));
`default_nettype wire
